// ===== hic_host_irq_controller.sv
`timescale 1ns/1ps
module hic_host_irq_controller
    import hic_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic [NUM_SYS-1:0] sys_irq,
    input  wire hic_bus_t           bus,
    output logic      [31:0]        rd_data,
    output logic                    fast_host_line,
    output logic                    normal_host_line,
    output logic      [31:0]        fast_vector,
    output logic      [31:0]        normal_vector
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] base,
                                 input int                k);
        hit = (a == ADDR_W'(int'(base) + WORD_BYTES * k));
    endfunction

    function automatic int line_of(input logic [4:0] c);
        line_of = (int'(c) < FAST_CHAN) ? 0 : 1;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic [NUM_SYS-1:0]  raw_r;
    logic [NUM_SYS-1:0]  en_r;
    logic [4:0]          chan_r      [NUM_SYS];
    logic                hold_r;
    logic [1:0]          mode_r;
    logic                ger_r;
    logic [NUM_LINE-1:0] host_en_r;
    logic [31:0]         vbase_r;
    logic [31:0]         vstride_r;
    logic [31:0]         vnull_r;
    logic [NEST_W-1:0]   gnest_r;
    logic [NEST_W-1:0]   gsave_r;
    logic                gforce_r;
    logic                gserv_r;
    logic [IDX_W-1:0]    gserv_idx_r;
    logic [NEST_W-1:0]   lnest_r     [NUM_LINE];
    logic [NEST_W-1:0]   lsave_r     [NUM_LINE];
    logic                lforce_r    [NUM_LINE];
    logic                lserv_r     [NUM_LINE];
    logic [IDX_W-1:0]    lserv_idx_r [NUM_LINE];
    logic                frz_r       [NUM_LINE];
    logic                frz_v_r     [NUM_LINE];
    logic [IDX_W-1:0]    frz_i_r     [NUM_LINE];
    logic [NUM_LINE-1:0] irq_r;
    logic [31:0]         vec_r       [NUM_LINE];
    logic [31:0]         rd_data_r;
    logic [31:0]         rd_nxt;

    logic [NUM_SYS-1:0]  pend;
    logic [NUM_SYS-1:0]  clr_stat;
    logic                live_v      [NUM_LINE];
    logic [IDX_W-1:0]    live_i      [NUM_LINE];
    logic                shown_v     [NUM_LINE];
    logic [IDX_W-1:0]    shown_i     [NUM_LINE];
    logic [31:0]         shown_vec   [NUM_LINE];
    logic                rd_hit      [NUM_LINE];
    logic                release_l   [NUM_LINE];
    logic                take        [NUM_LINE];
    logic                done_l      [NUM_LINE];
    logic                gtake;
    logic                gdone;
    logic [IDX_W-1:0]    gtake_i;
    logic [4:0]          gtake_c;
    logic                wr_gnest;
    logic [IDX_W-1:0]    widx;

    assign widx     = bus.wdata[IDX_W-1:0];
    assign pend     = raw_r & en_r;
    assign wr_gnest = bus.wr && bus.addr == OFS_GNEST;

    // ****************************************************************
    // status and enable banks
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SYS; gi++) begin : g_sys
            localparam int BK = gi / 32;
            localparam int BT = gi % 32;
            logic set_s;
            logic en_set;
            logic en_clr;
            assign set_s = sys_irq[gi]
                || (bus.wr && hit(bus.addr, OFS_RAW, BK) && bus.wdata[BT])
                || (bus.wr && bus.addr == OFS_SIDX_S && widx == IDX_W'(gi));
            assign clr_stat[gi] =
                (bus.wr && hit(bus.addr, OFS_ENSTAT, BK) && bus.wdata[BT])
                || (bus.wr && bus.addr == OFS_SIDX_C
                    && widx == IDX_W'(gi));
            assign en_set =
                (bus.wr && hit(bus.addr, OFS_ENSET, BK) && bus.wdata[BT])
                || (bus.wr && bus.addr == OFS_EIDX_S && widx == IDX_W'(gi));
            assign en_clr =
                (bus.wr && hit(bus.addr, OFS_ENCLR, BK) && bus.wdata[BT])
                || (bus.wr && bus.addr == OFS_EIDX_C
                    && widx == IDX_W'(gi));

            // set wins over clear; blocked channels keep pending
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    raw_r[gi] <= 1'b0;
                end else if (set_s) begin
                    raw_r[gi] <= 1'b1;
                end else if (clr_stat[gi]) begin
                    raw_r[gi] <= 1'b0;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    en_r[gi] <= 1'b0;
                end else if (en_set) begin
                    en_r[gi] <= 1'b1;
                end else if (en_clr) begin
                    en_r[gi] <= 1'b0;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    chan_r[gi] <= 5'h00;
                end else if (bus.wr && hit(bus.addr, OFS_CMAP, gi / 4)) begin
                    chan_r[gi] <= bus.wdata[8 * (gi % 4) +: 5];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r    <= 1'b0;
            mode_r    <= MODE_NONE;
            ger_r     <= 1'b0;
            vbase_r   <= 32'h0000_0000;
            vstride_r <= 32'h0000_0000;
            vnull_r   <= 32'h0000_0000;
        end else if (bus.wr) begin
            case (bus.addr)
                OFS_CTRL: begin
                    hold_r <= bus.wdata[CTRL_HOLD_BIT];
                    mode_r <= bus.wdata[CTRL_MODE_LSB +: 2];
                end
                OFS_GER:     ger_r     <= bus.wdata[0];
                OFS_VBASE:   vbase_r   <= bus.wdata;
                OFS_VSTRIDE: vstride_r <= bus.wdata;
                OFS_VNULL:   vnull_r   <= bus.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_en_r <= '0;
        end else if (bus.wr && bus.addr == OFS_HOST_LINE_ENABLE_REG) begin
            host_en_r <= bus.wdata[NUM_LINE-1:0];
        end else if (bus.wr && bus.addr == OFS_HIDX_S && int'(widx) < NUM_LINE) begin
            host_en_r[widx[0]] <= 1'b1;
        end else if (bus.wr && bus.addr == OFS_HIDX_C && int'(widx) < NUM_LINE) begin
            host_en_r[widx[0]] <= 1'b0;
        end
    end

    // ****************************************************************
    // per-line prioritization, hold and nesting
    // ****************************************************************
    generate
        for (gi = 0; gi < NUM_LINE; gi++) begin : g_line
            always_comb begin
                logic [4:0] best_c;
                logic       blk;
                best_c     = 5'h1f;
                blk        = 1'b0;
                live_v[gi] = 1'b0;
                live_i[gi] = '0;
                for (int i = 0; i < NUM_SYS; i++) begin
                    case (mode_r)
                        MODE_GLOBAL: blk = {4'h0, chan_r[i]} >= gnest_r;
                        MODE_LINE:   blk = {4'h0, chan_r[i]} >= lnest_r[gi];
                        default:     blk = 1'b0;
                    endcase
                    if (pend[i] && line_of(chan_r[i]) == gi && !blk
                        && (!live_v[gi] || chan_r[i] < best_c)) begin
                        live_v[gi] = 1'b1;
                        live_i[gi] = IDX_W'(i);
                        best_c     = chan_r[i];
                    end
                end
            end

            assign shown_v[gi] = frz_r[gi] ? frz_v_r[gi] : live_v[gi];
            assign shown_i[gi] = frz_r[gi] ? frz_i_r[gi] : live_i[gi];
            assign shown_vec[gi] = shown_v[gi]
                ? vbase_r + 32'(shown_i[gi]) * vstride_r * WORD_BYTES
                : vnull_r;
            assign rd_hit[gi] = bus.rd && (hit(bus.addr, OFS_PIDX, gi)
                                || hit(bus.addr, OFS_PVEC, gi));
            assign release_l[gi] = bus.wr && (hit(bus.addr, OFS_PIDX, gi)
                || hit(bus.addr, OFS_PVEC, gi))
                || (bus.wr && bus.addr == OFS_HOST_LINE_ENABLE_REG && bus.wdata[gi])
                || (bus.wr && (bus.addr == OFS_HIDX_S
                    || bus.addr == OFS_HIDX_C)
                    && widx == IDX_W'(gi));
            assign take[gi] = rd_hit[gi] && shown_v[gi]
                && !(lserv_r[gi] && lserv_idx_r[gi] == shown_i[gi]);
            assign done_l[gi] = lserv_r[gi] && clr_stat[lserv_idx_r[gi]];

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    frz_r[gi]   <= 1'b0;
                    frz_v_r[gi] <= 1'b0;
                    frz_i_r[gi] <= '0;
                end else if (!hold_r || release_l[gi]) begin
                    frz_r[gi] <= 1'b0;
                end else if (rd_hit[gi] && !frz_r[gi]) begin
                    frz_r[gi]   <= 1'b1;
                    frz_v_r[gi] <= live_v[gi];
                    frz_i_r[gi] <= live_i[gi];
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    lnest_r[gi]     <= NEST_IDLE;
                    lsave_r[gi]     <= NEST_IDLE;
                    lforce_r[gi]    <= 1'b0;
                    lserv_r[gi]     <= 1'b0;
                    lserv_idx_r[gi] <= '0;
                end else if (bus.wr && hit(bus.addr, OFS_LNEST, gi)) begin
                    lforce_r[gi] <= bus.wdata[FORCE_BIT];
                    if (bus.wdata[FORCE_BIT]) begin
                        lnest_r[gi] <= bus.wdata[NEST_W-1:0];
                    end
                end else if (take[gi] && mode_r == MODE_LINE) begin
                    lserv_r[gi]     <= 1'b1;
                    lserv_idx_r[gi] <= shown_i[gi];
                    lsave_r[gi]     <= lnest_r[gi];
                    if (!lforce_r[gi]) begin
                        lnest_r[gi] <= {4'h0, chan_r[shown_i[gi]]};
                    end
                end else if (done_l[gi]) begin
                    lserv_r[gi] <= 1'b0;
                    if (!lforce_r[gi]) begin
                        lnest_r[gi] <= lsave_r[gi];
                    end
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    irq_r[gi] <= 1'b0;
                    vec_r[gi] <= 32'h0000_0000;
                end else begin
                    irq_r[gi] <= ger_r && host_en_r[gi] && live_v[gi];
                    vec_r[gi] <= shown_vec[gi];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // global nesting
    // ****************************************************************
    always_comb begin
        gtake   = 1'b0;
        gtake_i = '0;
        for (int l = NUM_LINE - 1; l >= 0; l--) begin
            if (rd_hit[l] && shown_v[l]) begin
                gtake   = 1'b1;
                gtake_i = shown_i[l];
            end
        end
        gtake_c = chan_r[gtake_i];
        if (gserv_r && gserv_idx_r == gtake_i) begin
            gtake = 1'b0;
        end
    end

    assign gdone = gserv_r && clr_stat[gserv_idx_r];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gnest_r     <= NEST_IDLE;
            gsave_r     <= NEST_IDLE;
            gforce_r    <= 1'b0;
            gserv_r     <= 1'b0;
            gserv_idx_r <= '0;
        end else if (wr_gnest) begin
            gnest_r  <= bus.wdata[NEST_W-1:0];
            gforce_r <= bus.wdata[FORCE_BIT];
        end else if (gtake && mode_r == MODE_GLOBAL) begin
            gserv_r     <= 1'b1;
            gserv_idx_r <= gtake_i;
            gsave_r     <= gnest_r;
            if (!gforce_r) begin
                gnest_r <= {4'h0, gtake_c};
            end
        end else if (gdone) begin
            gserv_r <= 1'b0;
            if (!gforce_r) begin
                gnest_r <= gsave_r;
            end
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (bus.addr)
            OFS_REVID: rd_nxt = REV_ID;
            OFS_CTRL: begin
                rd_nxt[CTRL_HOLD_BIT]       = hold_r;
                rd_nxt[CTRL_MODE_LSB +: 2] = mode_r;
            end
            OFS_GER:     rd_nxt[0] = ger_r;
            OFS_GNEST:   rd_nxt[NEST_W-1:0] = gnest_r;
            OFS_HOST_LINE_ENABLE_REG:    rd_nxt[NUM_LINE-1:0] = host_en_r;
            OFS_VBASE:   rd_nxt = vbase_r;
            OFS_VSTRIDE: rd_nxt = vstride_r;
            OFS_VNULL:   rd_nxt = vnull_r;
            default: ;
        endcase
        for (int k = 0; k < NUM_SYS; k++) begin
            if (hit(bus.addr, OFS_RAW, k / 32)) begin
                rd_nxt[k % 32] = raw_r[k];
            end
            if (hit(bus.addr, OFS_ENSTAT, k / 32)) begin
                rd_nxt[k % 32] = pend[k];
            end
            if (hit(bus.addr, OFS_ENSET, k / 32)
                || hit(bus.addr, OFS_ENCLR, k / 32)) begin
                rd_nxt[k % 32] = en_r[k];
            end
            if (hit(bus.addr, OFS_CMAP, k / 4)) begin
                rd_nxt[8 * (k % 4) +: 5] = chan_r[k];
            end
        end
        for (int l = 0; l < NUM_LINE; l++) begin
            if (hit(bus.addr, OFS_PIDX, l)) begin
                rd_nxt = shown_v[l] ? 32'(shown_i[l]) : 32'h0000_0000;
                rd_nxt[NONE_BIT] = !shown_v[l];
            end
            if (hit(bus.addr, OFS_PVEC, l)) begin
                rd_nxt = shown_vec[l];
            end
            if (hit(bus.addr, OFS_LNEST, l)) begin
                rd_nxt[NEST_W-1:0] = lnest_r[l];
                rd_nxt[FORCE_BIT]  = lforce_r[l];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= 32'h0000_0000;
        end else begin
            rd_data_r <= bus.rd ? rd_nxt : 32'h0000_0000;
        end
    end

    assign rd_data          = rd_data_r;
    assign fast_host_line   = irq_r[0];
    assign normal_host_line = irq_r[1];
    assign fast_vector      = vec_r[0];
    assign normal_vector    = vec_r[1];

endmodule

// ===== hic_pkg.sv
// What this block does
// - under hold, writing a line's index or vector register releases both frozen values
// - writing host line enable register bit n releases line n's frozen values
// - writing n to indexed host enable set or clear releases line n's frozen values
// - three nesting methods exist, selected by the control register mode field; manual mode (3) blocks nothing here, same as none
// - global mode: taking an interrupt blocks its channel and all higher-numbered channels
// - service done restores the prior level; idle means nothing blocked by nesting
// - global nest level register is readable and writable by software
// - per-line mode: taking an interrupt changes only that line's nest level
// - per-line mode: a line's level blocks only channels mapped to that line; other lines still fire
// - one nest level register per host line, showing and setting the level
// - with force clear, line nest register shows the active interrupt's level
// - line nest write with force set loads the written level
// - vector is base plus index times per-routine size in words
// - with nothing pending the vector reads the null routine address
// - writing 1 at bit N of enabled-status clear bank clears status N
// - writing N to the indexed status clear register clears status N
// - writing 1 at bit N of enable clear bank disables interrupt N
// - writing N to the indexed enable clear register disables interrupt N
// - mode field codes: 0 none, 1 per-line, 2 global, 3 manual
// - global level force bit 31 reads 0; level field is bits 8-0
// - under hold, reading line index or vector freezes both for that line
package hic_pkg;

    localparam int NUM_SYS   = 101;
    localparam int NUM_CHAN  = 32;
    localparam int NUM_LINE  = 2;
    localparam int FAST_CHAN = 2;
    localparam int ADDR_W    = 13;
    localparam int NEST_W    = 9;
    localparam int IDX_W     = 7;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFS_REVID   = 13'h0000;
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 13'h0004;
    localparam logic [ADDR_W-1:0] OFS_GER     = 13'h0010;
    localparam logic [ADDR_W-1:0] OFS_GNEST   = 13'h001c;
    localparam logic [ADDR_W-1:0] OFS_SIDX_S  = 13'h0020;
    localparam logic [ADDR_W-1:0] OFS_SIDX_C  = 13'h0024;
    localparam logic [ADDR_W-1:0] OFS_EIDX_S  = 13'h0028;
    localparam logic [ADDR_W-1:0] OFS_EIDX_C  = 13'h002c;
    localparam logic [ADDR_W-1:0] OFS_HIDX_S  = 13'h0034;
    localparam logic [ADDR_W-1:0] OFS_HIDX_C  = 13'h0038;
    localparam logic [ADDR_W-1:0] OFS_VBASE   = 13'h0050;
    localparam logic [ADDR_W-1:0] OFS_VSTRIDE = 13'h0054;
    localparam logic [ADDR_W-1:0] OFS_VNULL   = 13'h0058;
    localparam logic [ADDR_W-1:0] OFS_RAW     = 13'h0200;
    localparam logic [ADDR_W-1:0] OFS_ENSTAT  = 13'h0280;
    localparam logic [ADDR_W-1:0] OFS_ENSET   = 13'h0300;
    localparam logic [ADDR_W-1:0] OFS_ENCLR   = 13'h0380;
    localparam logic [ADDR_W-1:0] OFS_CMAP    = 13'h0400;
    localparam logic [ADDR_W-1:0] OFS_PIDX    = 13'h0900;
    localparam logic [ADDR_W-1:0] OFS_LNEST   = 13'h1100;
    localparam logic [ADDR_W-1:0] OFS_HOST_LINE_ENABLE_REG    = 13'h1500;
    localparam logic [ADDR_W-1:0] OFS_PVEC    = 13'h1600;
    localparam int NUM_BANK = 4;
    localparam int NUM_CMAP = 26;

    // ****************************************************************
    // fields and reset values
    // ****************************************************************
    localparam int CTRL_HOLD_BIT = 4;
    localparam int CTRL_MODE_LSB = 2;
    localparam int FORCE_BIT     = 31;
    localparam int NONE_BIT      = 31;
    localparam int WORD_BYTES    = 4;
    localparam logic [1:0] MODE_NONE   = 2'h0;
    localparam logic [1:0] MODE_LINE   = 2'h1;
    localparam logic [1:0] MODE_GLOBAL = 2'h2;
    localparam logic [1:0] MODE_MANUAL = 2'h3;
    localparam logic [NEST_W-1:0] NEST_IDLE = 9'h1ff;
    localparam logic [31:0] REV_ID = 32'h0001_0000; // arbitrary value

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } hic_bus_t;

endpackage

// ===== hic_host_irq_controller_props.sv
`timescale 1ns/1ps
module hic_props
    import hic_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire hic_bus_t    bus,
    input wire logic [31:0] rd_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd(logic [ADDR_W-1:0] a);
        bus.rd && bus.addr == a;
    endsequence
    sequence s_wr_rd(logic [ADDR_W-1:0] a);
        bus.wr && bus.addr == a ##1 !bus.wr && !bus.rd ##1 s_rd(a);
    endsequence
    sequence s_force;
        bus.wr && bus.addr == OFS_LNEST + 13'h4 && bus.wdata[31];
    endsequence
    a_rd_idle_zero: assert property (
        !bus.rd |=> rd_data == 32'h0)
        else $error("read data seen without a read");
    a_gnest_high: assert property (
        s_rd(OFS_GNEST) |=> rd_data[31:9] == 23'h0)
        else $error("global level read shows high bits");
    a_gnest_loads: assert property (
        s_wr_rd(OFS_GNEST) |=> rd_data[8:0] == $past(bus.wdata[8:0], 3))
        else $error("global level not loaded by write");
    a_lnest_force: assert property (
        s_force ##1 !bus.wr ##1 s_rd(OFS_LNEST + 13'h4)
        |=> rd_data == {1'b1, 22'h0, $past(bus.wdata[8:0], 3)})
        else $error("forced line level not loaded");
    a_ctrl_fields: assert property (
        s_rd(OFS_CTRL) |=> rd_data[31:5] == 27'h0 && rd_data[1:0] == 2'h0)
        else $error("control reserved bits set");
    a_sclr_wonly: assert property (
        s_rd(OFS_SIDX_C) |=> rd_data == 32'h0)
        else $error("status index clear reads nonzero");
    a_eclr_wonly: assert property (
        s_rd(OFS_EIDX_C) |=> rd_data == 32'h0)
        else $error("enable index clear reads nonzero");
    a_idx_none: assert property (
        s_rd(OFS_PIDX + 13'h4) ##1 rd_data[31] |-> rd_data == 32'h8000_0000)
        else $error("empty index has stray bits");
endmodule

bind hic_host_irq_controller hic_props i_props (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data));

// ===== hic_core_model.sv
`timescale 1ns/1ps
module hic_core_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic normal_host_line,
    output int        n_norm
);
    logic norm_r;
    // counts handler entries: one per rising line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            norm_r <= 1'b0;
            n_norm <= 0;
        end else begin
            norm_r <= normal_host_line;
            n_norm <= n_norm + int'(normal_host_line && !norm_r);
        end
    end
endmodule

// ===== hic_host_irq_controller_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module hic_host_irq_controller_tb
    import hic_pkg::*;
;
    logic               clk, rst_n, fline, nline;
    logic [NUM_SYS-1:0] sys_irq;
    hic_bus_t           bus;
    logic [31:0]        rd_data, rv, vb, vs, vn, bm, fvec, nvec, x[$];
    logic [12:0]        bo, q[$];
    int                 n_fail, n_checks, n_norm, chan[NUM_SYS], k, f, e;
    bit                 pend[NUM_SYS], en[NUM_SYS];
    hic_host_irq_controller i_dut (.clk(clk), .rst_n(rst_n),
        .sys_irq(sys_irq), .bus(bus), .rd_data(rd_data),
        .fast_host_line(fline), .normal_host_line(nline),
        .fast_vector(fvec), .normal_vector(nvec));
    hic_core_model i_core (.clk(clk), .rst_n(rst_n),
        .normal_host_line(nline), .n_norm(n_norm));
    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [12:0] a);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        bus <= '0;
        #1 rv = rd_data;
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        sys_irq[i] <= 1'b1;
        pend[i] = 1;
        @(posedge clk);
        sys_irq <= '0;
        repeat (2) @(posedge clk);
    endtask
    task automatic setup(input int i, input int c);
        logic [31:0] w;
        chan[i] = c;
        en[i] = 1;
        w = '0;
        for (int j = 0; j < 4; j++)
            if (i / 4 * 4 + j < NUM_SYS)
                w[8 * j +: 5] = 5'(chan[i / 4 * 4 + j]);
        wr(OFS_CMAP + 13'(i / 4 * 4), w);
        wr(OFS_EIDX_S, 32'(i));
    endtask
    // model winner: lowest channel, then lowest index
    function automatic int best(input int ln);
        for (int c = ln * 2; c < (ln ? NUM_CHAN : 2); c++)
            for (int i = 0; i < NUM_SYS; i++)
                if (pend[i] && en[i] && chan[i] == c)
                    return i;
        return -1;
    endfunction
    task automatic chk_line(input int ln, input int i);
        logic [31:0] ev;
        ev = i < 0 ? vn : vb + 32'(i) * vs * 32'h4;
        rd(OFS_PIDX + 13'(4 * ln));
        `CHK(rv, i < 0 ? 32'h8000_0000 : 32'(i))
        rd(OFS_PVEC + 13'(4 * ln));
        `CHK(rv, ev)
        `CHK(ln ? nvec : fvec, ev)
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 20000);
        n_fail++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        sys_irq = '0;
        bus = '0;
        rv = $urandom(32'hd172aad6);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        q = '{OFS_REVID, OFS_CTRL, OFS_GNEST, OFS_LNEST, OFS_SIDX_C,
              OFS_EIDX_C, 13'h1ffc};
        x = '{REV_ID, 0, 32'h1ff, 32'h1ff, 0, 0, 0};
        foreach (q[i]) begin
            rd(q[i]);
            `CHK(rv, x[i])
        end
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CTRL, 32'(m << 2));
            rd(OFS_CTRL);
            `CHK(rv, 32'(m << 2))
        end
        rv = $urandom;
        e = rv[8:0];
        wr(OFS_GNEST, rv | 32'h8000_0000);
        rd(OFS_GNEST);
        `CHK(rv, 32'(e))
        wr(OFS_GNEST, 32'h1ff);
        vb = $urandom;
        vs = $urandom % 256;
        vn = $urandom;
        wr(OFS_VBASE, vb);
        wr(OFS_VSTRIDE, vs);
        wr(OFS_VNULL, vn);
        wr(OFS_GER, 32'h1);
        wr(OFS_HOST_LINE_ENABLE_REG, 32'h3);
        k = $urandom % NUM_SYS;
        bo = 13'(4 * (k / 32));
        bm = 32'h1 << (k % 32);
        setup(k, 2 + $urandom % 30);
        for (int t = 0; t < 4; t++) begin
            if (t == 2)
                wr(OFS_ENCLR + bo, bm);
            if (t == 3)
                wr(OFS_EIDX_C, 32'(k));
            en[k] = t < 2;
            pulse(k);
            `CHK(nline, en[k])
            chk_line(1, en[k] ? k : -1);
            if (t == 1)
                wr(OFS_ENSTAT + bo, bm);
            else
                wr(OFS_SIDX_C, 32'(k));
            pend[k] = 0;
            wr(OFS_EIDX_S, 32'(k));
            en[k] = 1;
            chk_line(1, -1);
            `CHK(nline, 1'b0)
        end
        wr(OFS_CTRL, 32'h10);
        for (int i = 0; i < 5; i++) begin
            setup((k + 1 + 7 * i) % NUM_SYS, 2 + i);
            pulse((k + 1 + 7 * i) % NUM_SYS);
        end
        q = '{OFS_PIDX + 13'h4, OFS_PVEC + 13'h4, OFS_HOST_LINE_ENABLE_REG, OFS_HIDX_S,
              OFS_HIDX_C};
        x = '{0, 0, 3, 1, 1};
        foreach (q[i]) begin
            e = best(1);
            chk_line(1, e);
            wr(OFS_SIDX_C, 32'(e));
            pend[e] = 0;
            chk_line(1, e);
            wr(q[i], x[i]);
            chk_line(1, best(1));
        end
        wr(OFS_HIDX_S, 32'h1);
        wr(OFS_CTRL, 32'h4);
        f = (k + 40) % NUM_SYS;
        setup(k, 9);
        setup(f, 0);
        pulse(k);
        rd(OFS_PIDX + 13'h4);
        rd(OFS_LNEST + 13'h4);
        `CHK(rv, 32'h9)
        rd(OFS_LNEST);
        `CHK(rv, 32'h1ff)
        wr(OFS_LNEST + 13'h4, 32'h8000_0005);
        rd(OFS_LNEST + 13'h4);
        `CHK(rv, 32'h8000_0005)
        pulse(f);
        `CHK({fline, nline}, 2'b10)
        e = n_norm;
        wr(OFS_LNEST + 13'h4, 32'h8000_01ff);
        repeat (3) @(posedge clk);
        `CHK(n_norm, e + 1)
        wr(OFS_SIDX_C, 32'(k));
        wr(OFS_SIDX_C, 32'(f));
        pend[k] = 0;
        pend[f] = 0;
        wr(OFS_LNEST + 13'h4, 32'h1ff);
        wr(OFS_CTRL, 32'h8);
        setup(k, 4);
        setup(f, 6);
        pulse(k);
        rd(OFS_PIDX + 13'h4);
        pulse(f);
        rd(OFS_GNEST);
        `CHK(rv, 32'h4)
        `CHK(nline, 1'b0)
        wr(OFS_SIDX_C, 32'(k));
        pend[k] = 0;
        rd(OFS_GNEST);
        `CHK(rv, 32'h1ff)
        `CHK(nline, 1'b1)
        // hold keeps the vector of f although taking it nests it out
        wr(OFS_CTRL, 32'h18);
        chk_line(1, f);
        complete_run();
    end
endmodule
